// ===== design/tpo_map.svh
// Register offsets, field positions, reset values and sampling constants of the PWM output stage
`ifndef TPO_MAP_SVH
`define TPO_MAP_SVH
`define TPO_OFS_MODE     8'h00
`define TPO_OFS_CTRL     8'h04
`define TPO_OFS_STAT     8'h08
`define TPO_OFS_DEAD     8'h0C
`define TPO_OFS_PBUF     8'h10
`define TPO_OFS_PCMP     8'h14
`define TPO_OFS_BUF_U    8'h18
`define TPO_OFS_IMM_U    8'h24
`define TPO_OFS_MID_U    8'h30
`define TPO_OFS_CNT      8'h3C
`define TPO_OFS_SDCS     8'h40
`define TPO_OFS_STBY     8'h44
`define TPO_PHASE_STEP   8'h04
`define TPO_MODE_POS     0
`define TPO_MODE_NEG     1
`define TPO_MODE_RUN     2
`define TPO_MODE_SYNCOUT 3
`define TPO_MODE_PINOWN  4
`define TPO_CTRL_ADC_EN  0
`define TPO_CTRL_PK_IE   1
`define TPO_CTRL_TR_IE   2
`define TPO_CTRL_ADC_PK  3
`define TPO_CTRL_ADC_TR  4
`define TPO_CTRL_XF_PK   5
`define TPO_CTRL_XF_TR   6
`define TPO_STAT_PK      0
`define TPO_STAT_TR      1
`define TPO_SD_IE        8
`define TPO_SD_FLAG      12
`define TPO_STBY_RST     1'b1
`define TPO_PINOWN_RST   1'b1
`define TPO_MASK_D8      7'h07
`define TPO_MASK_D16     7'h0F
`define TPO_MASK_D128    7'h7F
`define TPO_LOW_SAMPLES  5'h10
`endif

// ===== design/tpo_pkg.sv
// Types of the PWM output stage: sampling modes, pin carrier and the state record
package tpo_pkg;
	typedef enum logic [1:0] {
		TPO_SD_EDGE = 2'b00,
		TPO_SD_D8   = 2'b01,
		TPO_SD_D16  = 2'b10,
		TPO_SD_D128 = 2'b11
	} tpo_sd_mode_e;

	// Bit order: u_pos, u_neg, v_pos, v_neg, w_pos, w_neg from bit 0 up
	typedef struct packed {
		logic [5:0] level;
		logic [5:0] oe;
	} tpo_pwm_s;

	typedef struct packed {
		logic [15:0]             cnt;
		logic                    up;
		logic [15:0]             per;
		logic [15:0]             pbuf;
		logic [15:0]             td;
		logic [2:0][15:0]        buff;
		logic [2:0][16:0]        mid;
		logic [5:0][15:0]        transfer_controller;
		logic [5:0]              cmo_prev;
		logic [5:0]              pins;
		logic                    sync_o;
		logic                    pos_phase_level_sel;
		logic                    neg_phase_level_sel;
		logic                    run;
		logic                    sync_dir;
		logic                    pin_own;
		logic [6:0]              ctl;
		logic [1:0]              flag;
		logic [1:0]              farm;
		logic                    adc_o;
		logic [1:0]              xfer_o;
		logic [2:0]              sd_s1;
		logic [2:0]              sd_s2;
		logic [2:0]              sd_prev;
		tpo_sd_mode_e [2:0]      sd_mode;
		logic                    sd_ie;
		logic [2:0]              sd_flag;
		logic [2:0]              sd_arm;
		logic [2:0][4:0]         sd_cnt;
		logic [6:0]              div;
		logic                    sy_s1;
		logic                    sy_s2;
		logic                    sy_prev;
		logic                    stby;
		logic                    pready;
		logic                    pslverr;
		logic [31:0]             prdata;
	} tpo_state_s;
endpackage

// ===== design/tpo_top.sv
// Three-phase complementary PWM output stage with carrier counter, triggers and output disable
// Behaviour
// [R01] Pin level follows output waveform through positive and negative level selects.
// [R02] Phase buffer zero gives 100% duty, positive phase always on.
// [R03] Phase buffer above period gives 0% duty, positive phase always off.
// [R04] Sync pin falling edge as input reloads counter with twice dead time.
// [R05] Sync pin as output is high counting up, low counting down.
// [R06] Converter start requests offered at peak or trough match.
// [R07] Converter requests only while converter trigger enable is one.
// [R08] Start request sent when match flag sets with trigger enabled.
// [R09] Stopped input clock puts all six PWM pins in high impedance.
// [R10] Peak and trough flags set on matches, interrupt when enabled.
// [R11] Match interrupt withdrawn as soon as its flag clears.
// [R12] Software clears flags only by reading one then writing zero.
// [R13] Transfer controller activated on matches; activation clears the flag.
// [R14] Reset leaves module standby on; registers reachable only after clearing it.
// [R15] Match during buffer write transfers the newly written buffer value.
// [R16] Match during direct compare write discards it; buffer value transferred.
// [R17] Software avoids mid compare writes of old value plus or minus dead time.
// [R18] Software changes period only through the period buffer while running.
// [R19] Software leaves dead time unchanged after the timer starts.
// [R20] Shutdown inputs detect falling edge or sixteen lows at /8, /16, /128.
// [R21] Shutdown condition forces six PWM pins to high impedance, optional interrupt.
// [R22] Standby and oscillator halt also force the six pins to high impedance.
// [R23] Forced high impedance applies only while pins belong to this block.
// [R24] Counter runs up from twice dead time to period, then back down.
// [R25] Each output waveform ANDs compare waveform with opposite dead-time waveform.
// [R26] Immediate-address buffer write loads the compare register at once.
// [R27] Sync pin and shutdown inputs pass two flip-flops before use.
`timescale 1ns/1ps
`include "tpo_map.svh"
module tpo_top (
	input  wire logic               core_clk_in,
	input  wire logic               arst_n_in,
	input  wire logic               psel_in,
	input  wire logic               penable_in,
	input  wire logic               pwrite_in,
	input  wire logic [7:0]         paddr_in,
	input  wire logic [31:0]        pwdata_in,
	output logic                    pready_out,
	output logic                    pslverr_out,
	output logic [31:0]             prdata_out,
	output tpo_pkg::tpo_pwm_s       pwm_out,
	input  wire logic               carrier_sync_pin_in,
	output logic                    carrier_sync_pin_out,
	output logic                    carrier_sync_pin_oe_out,
	input  wire logic [2:0]         shutdown_in,
	input  wire logic               sys_standby_in,
	input  wire logic               clk_stop_in,
	input  wire logic [1:0]         xfer_ack_in,
	output logic [1:0]              xfer_req_out,
	output logic                    adc_start_out,
	output logic                    peak_irq_out,
	output logic                    trough_irq_out,
	output logic                    shutdown_irq_out
);
	tpo_pkg::tpo_state_s s_ff;
	tpo_pkg::tpo_state_s nxt_s;

	logic        acc;
	logic        fire;
	logic        we;
	logic        gated;
	logic        hit;
	logic [31:0] rv;
	logic [7:0]  ofs;
	logic        run;
	logic        peak;
	logic        trough;
	logic [16:0] td2;
	logic        sync_fall;
	logic [5:0]  cmo;
	logic [5:0]  dtg;
	logic [5:0]  og;
	logic [17:0] mext;
	logic [17:0] upc;
	logic [17:0] dnc;
	logic [17:0] cext;
	logic [1:0]  fclr;
	logic [6:0]  mask;
	logic        det;
	logic        force_hiz;

	// Read mux of the register map
	always_comb begin
		ofs = paddr_in;
		hit = 1'b1;
		rv  = 32'h0000_0000;
		case (ofs)
			`TPO_OFS_MODE: rv[4:0] = {s_ff.pin_own, s_ff.sync_dir, s_ff.run, s_ff.neg_phase_level_sel, s_ff.pos_phase_level_sel};
			`TPO_OFS_CTRL: rv[6:0] = s_ff.ctl;
			`TPO_OFS_STAT: rv[1:0] = s_ff.flag;
			`TPO_OFS_DEAD: rv[15:0] = s_ff.td;
			`TPO_OFS_PBUF: rv[15:0] = s_ff.pbuf;
			`TPO_OFS_PCMP: rv[15:0] = s_ff.per;
			`TPO_OFS_CNT:  rv[15:0] = s_ff.cnt;
			`TPO_OFS_STBY: rv[0] = s_ff.stby;
			`TPO_OFS_SDCS: begin
				rv[5:0] = {s_ff.sd_mode[2], s_ff.sd_mode[1], s_ff.sd_mode[0]};
				rv[`TPO_SD_IE] = s_ff.sd_ie;
				rv[`TPO_SD_FLAG +: 3] = s_ff.sd_flag;
			end
			default: begin
				hit = 1'b0;
				for (int i = 0; i < 3; i++) begin
					if (ofs == `TPO_OFS_BUF_U + 8'(i * 4) || ofs == `TPO_OFS_IMM_U + 8'(i * 4)) begin
						rv[15:0] = s_ff.buff[i];
						hit = 1'b1;
					end
					if (ofs == `TPO_OFS_MID_U + 8'(i * 4)) begin
						rv[16:0] = s_ff.mid[i];
						hit = 1'b1;
					end
				end
			end
		endcase
	end

	// Pure zero-wait would be simpler, but one wait state keeps read data registered
	always_comb begin
		nxt_s = s_ff;
		acc   = psel_in & penable_in;
		fire  = acc & s_ff.pready;
		gated = s_ff.stby & (ofs != `TPO_OFS_STBY); // [R14]
		nxt_s.pready = acc & ~s_ff.pready;
		if (acc & ~s_ff.pready) begin
			nxt_s.pslverr = gated | ~hit;
			nxt_s.prdata  = (gated | ~hit) ? 32'h0000_0000 : rv;
		end
		we = fire & pwrite_in & ~s_ff.pslverr;

		// Carrier counter and matches
		td2       = {s_ff.td, 1'b0};
		run       = s_ff.run & ~s_ff.stby;
		peak      = run & s_ff.up & (s_ff.cnt == s_ff.per);
		trough    = run & ~s_ff.up & ({1'b0, s_ff.cnt} == td2);
		sync_fall = s_ff.sy_prev & ~s_ff.sy_s2;
		nxt_s.sy_s1   = carrier_sync_pin_in; // [R27]
		nxt_s.sy_s2   = s_ff.sy_s1;
		nxt_s.sy_prev = s_ff.sy_s2;
		if (!run || (sync_fall && !s_ff.sync_dir)) begin
			nxt_s.cnt = td2[15:0]; // [R04]
			nxt_s.up  = 1'b1;
		end else if (s_ff.up) begin
			if (s_ff.cnt >= s_ff.per) begin
				nxt_s.up  = 1'b0; // [R24]
				nxt_s.cnt = s_ff.cnt - 16'h0001;
			end else begin
				nxt_s.cnt = s_ff.cnt + 16'h0001;
			end
		end else if ({1'b0, s_ff.cnt} <= td2) begin
			nxt_s.up  = 1'b1; // [R24]
			nxt_s.cnt = s_ff.cnt + 16'h0001;
		end else begin
			nxt_s.cnt = s_ff.cnt - 16'h0001;
		end
		nxt_s.sync_o = s_ff.up; // [R05]

		// Register writes
		if (we) begin
			case (ofs)
				`TPO_OFS_MODE: begin
					nxt_s.pos_phase_level_sel     = pwdata_in[`TPO_MODE_POS];
					nxt_s.neg_phase_level_sel     = pwdata_in[`TPO_MODE_NEG];
					nxt_s.run      = pwdata_in[`TPO_MODE_RUN];
					nxt_s.sync_dir = pwdata_in[`TPO_MODE_SYNCOUT];
					nxt_s.pin_own  = pwdata_in[`TPO_MODE_PINOWN];
				end
				`TPO_OFS_CTRL: nxt_s.ctl = pwdata_in[6:0];
				`TPO_OFS_DEAD: nxt_s.td = pwdata_in[15:0]; // Must stay fixed while running
				`TPO_OFS_PBUF: nxt_s.pbuf = pwdata_in[15:0];
				`TPO_OFS_PCMP: nxt_s.per = pwdata_in[15:0];
				`TPO_OFS_STBY: nxt_s.stby = pwdata_in[0];
				`TPO_OFS_SDCS: begin
					for (int k = 0; k < 3; k++) begin
						nxt_s.sd_mode[k] = tpo_pkg::tpo_sd_mode_e'(pwdata_in[2*k +: 2]);
					end
					nxt_s.sd_ie = pwdata_in[`TPO_SD_IE];
				end
				default: begin
					for (int i = 0; i < 3; i++) begin
						if (ofs == `TPO_OFS_BUF_U + 8'(i * 4)) begin
							nxt_s.buff[i] = pwdata_in[15:0];
						end
						if (ofs == `TPO_OFS_IMM_U + 8'(i * 4)) begin
							nxt_s.buff[i] = pwdata_in[15:0];
							nxt_s.mid[i]  = {1'b0, pwdata_in[15:0]} + {1'b0, s_ff.td}; // [R26]
						end
						if (ofs == `TPO_OFS_MID_U + 8'(i * 4)) begin
							nxt_s.mid[i] = pwdata_in[16:0];
						end
					end
				end
			endcase
		end

		// Buffer transfer at peak and trough; taken after the write so contention resolves correctly
		if (peak | trough) begin
			nxt_s.per = 16'(nxt_s.pbuf + {s_ff.td[14:0], 1'b0}); // [R15] [R16]
			for (int i = 0; i < 3; i++) begin
				nxt_s.mid[i] = {1'b0, nxt_s.buff[i]} + {1'b0, s_ff.td}; // [R15] [R16]
			end
		end

		// Compare waveforms per phase, mid compare drives up and down thresholds
		cext = {2'b00, s_ff.cnt};
		mext = 18'h0_0000;
		upc  = 18'h0_0000;
		dnc  = 18'h0_0000;
		for (int i = 0; i < 3; i++) begin
			mext = {1'b0, s_ff.mid[i]};
			upc  = mext + {2'b00, s_ff.td};
			dnc  = mext - {2'b00, s_ff.td};
			cmo[2*i]   = s_ff.up ? (cext >= upc) : (cext >= mext); // [R02] [R03]
			cmo[2*i+1] = s_ff.up ? (cext < mext) : (cext < dnc);
		end

		// Dead-time counters start on a falling compare edge; zero dead time skips them
		for (int j = 0; j < 6; j++) begin
			dtg[j] = (s_ff.transfer_controller[j] == 16'h0000);
			if (!dtg[j]) begin
				nxt_s.transfer_controller[j] = (s_ff.transfer_controller[j] >= s_ff.td) ? 16'h0000 : s_ff.transfer_controller[j] + 16'h0001;
			end else if (s_ff.cmo_prev[j] && !cmo[j] && s_ff.td != 16'h0000 && run) begin
				nxt_s.transfer_controller[j] = 16'h0001;
			end
		end
		nxt_s.cmo_prev = cmo;
		for (int i = 0; i < 3; i++) begin
			og[2*i]   = cmo[2*i] & dtg[2*i+1]; // [R25]
			og[2*i+1] = cmo[2*i+1] & dtg[2*i]; // [R25]
			nxt_s.pins[2*i]   = (run & og[2*i]) ~^ s_ff.pos_phase_level_sel; // [R01]
			nxt_s.pins[2*i+1] = (run & og[2*i+1]) ~^ s_ff.neg_phase_level_sel; // [R01]
		end

		// Match flags: set wins over clear
		if (fire & ~pwrite_in & ~s_ff.pslverr & ofs == `TPO_OFS_STAT) begin
			nxt_s.farm = s_ff.flag; // [R12]
		end
		fclr = xfer_ack_in; // [R13]
		if (we & ofs == `TPO_OFS_STAT) begin
			fclr = fclr | (s_ff.farm & ~pwdata_in[1:0]); // [R12]
			nxt_s.farm = 2'b00;
		end
		nxt_s.flag[`TPO_STAT_PK] = peak | (s_ff.flag[0] & ~fclr[0]); // [R10]
		nxt_s.flag[`TPO_STAT_TR] = trough | (s_ff.flag[1] & ~fclr[1]); // [R10]
		nxt_s.adc_o = s_ff.ctl[`TPO_CTRL_ADC_EN] & ((peak & s_ff.ctl[`TPO_CTRL_ADC_PK])
			| (trough & s_ff.ctl[`TPO_CTRL_ADC_TR])); // [R06] [R07] [R08]
		nxt_s.xfer_o = {trough & s_ff.ctl[`TPO_CTRL_XF_TR], peak & s_ff.ctl[`TPO_CTRL_XF_PK]}; // [R13]

		// Shutdown inputs: synchronise, then edge or sampled-low detection
		nxt_s.div     = s_ff.div + 7'h01;
		nxt_s.sd_s1   = shutdown_in; // [R27]
		nxt_s.sd_s2   = s_ff.sd_s1;
		nxt_s.sd_prev = s_ff.sd_s2;
		if (fire & ~pwrite_in & ~s_ff.pslverr & ofs == `TPO_OFS_SDCS) begin
			nxt_s.sd_arm = s_ff.sd_flag;
		end
		for (int k = 0; k < 3; k++) begin
			det = 1'b0;
			case (s_ff.sd_mode[k])
				tpo_pkg::TPO_SD_D8:   mask = `TPO_MASK_D8;
				tpo_pkg::TPO_SD_D16:  mask = `TPO_MASK_D16;
				tpo_pkg::TPO_SD_D128: mask = `TPO_MASK_D128;
				default:              mask = 7'h00;
			endcase
			if (s_ff.sd_mode[k] == tpo_pkg::TPO_SD_EDGE) begin
				det = s_ff.sd_prev[k] & ~s_ff.sd_s2[k]; // [R20]
				nxt_s.sd_cnt[k] = 5'h00;
			end else if ((s_ff.div & mask) == mask) begin
				if (s_ff.sd_s2[k] || s_ff.sd_cnt[k] + 5'h01 == `TPO_LOW_SAMPLES) begin
					det = ~s_ff.sd_s2[k]; // [R20]
					nxt_s.sd_cnt[k] = 5'h00;
				end else begin
					nxt_s.sd_cnt[k] = s_ff.sd_cnt[k] + 5'h01;
				end
			end
			nxt_s.sd_flag[k] = det | (s_ff.sd_flag[k]
				& ~(we & ofs == `TPO_OFS_SDCS & s_ff.sd_arm[k] & ~pwdata_in[`TPO_SD_FLAG + k])); // [R12]
		end
		if (we & ofs == `TPO_OFS_SDCS) begin
			nxt_s.sd_arm = 3'b000;
		end
	end

	// Single state register
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_ff         <= '0;
			s_ff.stby    <= `TPO_STBY_RST; // [R14]
			s_ff.pin_own <= `TPO_PINOWN_RST;
			s_ff.up      <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Clock-stop level is used without registers since no edge may arrive to capture it
	assign force_hiz = (|s_ff.sd_flag) | sys_standby_in | clk_stop_in; // [R09] [R21] [R22]

	// Output drive
	assign pwm_out.level            = s_ff.pins;
	assign pwm_out.oe               = {6{s_ff.pin_own & ~force_hiz}}; // [R23]
	assign pready_out               = s_ff.pready;
	assign pslverr_out              = s_ff.pslverr;
	assign prdata_out               = s_ff.prdata;
	assign carrier_sync_pin_out     = s_ff.sync_o; // [R05]
	assign carrier_sync_pin_oe_out  = s_ff.sync_dir;
	assign xfer_req_out             = s_ff.xfer_o;
	assign adc_start_out            = s_ff.adc_o;
	assign peak_irq_out             = s_ff.flag[0] & s_ff.ctl[`TPO_CTRL_PK_IE]; // [R10] [R11]
	assign trough_irq_out           = s_ff.flag[1] & s_ff.ctl[`TPO_CTRL_TR_IE]; // [R10] [R11]
	assign shutdown_irq_out         = s_ff.sd_ie & (|s_ff.sd_flag); // [R21]
endmodule // tpo_top

// ===== tb/tpo_monitor.sv
// Port checker for the PWM output stage
`timescale 1ns/1ps
module tpo_monitor (
	input wire logic         core_clk_in,
	input wire logic         arst_n_in,
	input wire logic         psel_in,
	input wire logic         penable_in,
	input wire logic         pwrite_in,
	input wire logic [7:0]   paddr_in,
	input wire logic         pready_out,
	input wire logic         pslverr_out,
	input tpo_pkg::tpo_pwm_s pwm_out,
	input wire logic [1:0]   xfer_ack_in,
	input wire logic         sys_standby_in,
	input wire logic         clk_stop_in,
	input wire logic         peak_irq_out,
	input wire logic         trough_irq_out,
	input wire logic         shutdown_irq_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	// Any completed write or an activation ack may drop a match request
	logic [1:0] clr;
	assign clr = {2{pready_out && pwrite_in}} | xfer_ack_in;
	sequence s_wait;
		psel_in && penable_in && !pready_out;
	endsequence
	property p_wait; s_wait |=> pready_out; endproperty
	property p_pulse; pready_out |=> !pready_out; endproperty
	property p_err; pready_out && paddr_in == 8'h48 |-> pslverr_out; endproperty
	property p_clk; clk_stop_in |-> pwm_out.oe == 6'h00; endproperty
	property p_stby; sys_standby_in |-> pwm_out.oe == 6'h00; endproperty
	property p_sd; shutdown_irq_out |-> pwm_out.oe == 6'h00; endproperty
	property p_pk; $fell(peak_irq_out) |-> $past(clr[0]) || $past(clr[0], 2); endproperty
	property p_tr; $fell(trough_irq_out) |-> $past(clr[1]) || $past(clr[1], 2); endproperty
	a_wait: assert property (p_wait) else $error("no answer after one wait state");
	a_pulse: assert property (p_pulse) else $error("ready held too long");
	a_err: assert property (p_err) else $error("unmapped access not refused");
	a_clk: assert property (p_clk) else $error("pins driven with clock stopped");
	a_stby: assert property (p_stby) else $error("pins driven in standby");
	a_sd: assert property (p_sd) else $error("pins driven after shutdown");
	a_pk: assert property (p_pk) else $error("peak request dropped without clear");
	a_tr: assert property (p_tr) else $error("trough request dropped without clear");
endmodule // tpo_monitor
bind tpo_top tpo_monitor i_mon (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .pwm_out(pwm_out), .xfer_ack_in(xfer_ack_in), .sys_standby_in(sys_standby_in),
	.clk_stop_in(clk_stop_in), .peak_irq_out(peak_irq_out), .trough_irq_out(trough_irq_out),
	.shutdown_irq_out(shutdown_irq_out));

// ===== tb/tpo_partner.sv
// Fault inputs and transfer controller seen from the far side
`timescale 1ns/1ps
module tpo_partner (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [1:0] req_in,
	input  wire logic       ack_en_in,
	input  wire logic [2:0] fault_in,
	output logic [2:0]      shutdown_out,
	output logic [1:0]      ack_out
);
	logic [1:0] dly_ff;
	// Fault lines are pulled up, so a released line reads high
	assign shutdown_out = ~fault_in;
	// Controller answers two cycles late, like a busy transfer engine
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dly_ff <= 2'h0;
			ack_out <= 2'h0;
		end else begin
			dly_ff <= req_in & {2{ack_en_in}};
			ack_out <= dly_ff;
		end
	end
endmodule // tpo_partner

// ===== tb/three_phase_pwm_output_stage_test.sv
// Self-checking bench of the PWM output stage
`timescale 1ns/1ps
`include "tpo_map.svh"
module three_phase_pwm_output_stage_test;
	logic              clk = 0, rst_n, psel, pen, pwr, prdy, perr, so, soe, stby, cstop, adc, pk, tr, sdi;
	logic [7:0]        pa;
	logic [31:0]       pwd, prd, q;
	logic [2:0]        fault, sd;
	logic [1:0]        ack, xreq;
	logic              sdrv_en, sdrv, e;
	wire               sync_w;
	tpo_pkg::tpo_pwm_s pwm;
	int                error_cnt, compares, adc_n, xf_n, up_n, dn_n, i, m, dv;
	always #2.5 clk = ~clk;
	// Two-way sync pin with pull-up when nobody drives it
	assign sync_w = soe ? so : (sdrv_en ? sdrv : 1'b1);
	tpo_top i_dut (.core_clk_in(clk), .arst_n_in(rst_n), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(pa), .pwdata_in(pwd), .pready_out(prdy), .pslverr_out(perr), .prdata_out(prd), .pwm_out(pwm),
		.carrier_sync_pin_in(sync_w), .carrier_sync_pin_out(so), .carrier_sync_pin_oe_out(soe),
		.shutdown_in(sd), .sys_standby_in(stby), .clk_stop_in(cstop), .xfer_ack_in(ack), .xfer_req_out(xreq),
		.adc_start_out(adc), .peak_irq_out(pk), .trough_irq_out(tr), .shutdown_irq_out(sdi));
	tpo_partner i_far (.clk_in(clk), .rst_n_in(rst_n), .req_in(xreq), .ack_en_in(1'b1), .fault_in(fault),
		.shutdown_out(sd), .ack_out(ack));
	// Event counters for pulses and sync level
	always @(posedge clk) begin
		if (adc === 1'b1) adc_n++;
		if (xreq !== 2'b00) xf_n++;
		if (soe === 1'b1 && so === 1'b1) up_n++;
		if (soe === 1'b1 && so === 1'b0) dn_n++;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer; request held until ready is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 20);
		// A missing answer is a mismatch, not a silent pass
		if (n >= 20) error_cnt++;
		q = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		// Idle edge so the next call never reassigns psel in this time step
		@(posedge clk);
	endtask
	task automatic wait_pk;
		int n;
		n = 0;
		while (pk !== 1'b1 && n < 200) begin @(posedge clk); n++; end
	endtask
	task automatic report_and_stop;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog: the sequence needs about 6000 cycles
	initial begin
		#100000;
		error_cnt++;
		report_and_stop;
	end
	initial begin
		{psel, pen, pwr, pa, pwd, rst_n, stby, cstop, fault, sdrv_en, sdrv} = '0;
		i = $urandom(53199);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(0, `TPO_OFS_STBY, 0); chk("stby", q, 32'h1);
		bus(0, `TPO_OFS_MODE, 0); chk("stby_err", {q[30:0], e}, 32'h1);
		bus(1, `TPO_OFS_STBY, 0);
		bus(0, 8'h48, 0); chk("unmapped", 32'(e), 32'h1);
		bus(1, `TPO_OFS_DEAD, 2);
		bus(1, `TPO_OFS_PBUF, 20);
		bus(1, `TPO_OFS_PCMP, 24);
		// Phase U full on, V full off, W random mid duty; written before the run starts
		for (i = 0; i < 3; i++) begin
			dv = (i == 0) ? 0 : (i == 1) ? 256 : 1 + $urandom % 18;
			bus(1, `TPO_OFS_IMM_U + 8'(4 * i), dv);
		end
		bus(1, `TPO_OFS_CTRL, 32'h1F);
		bus(1, `TPO_OFS_MODE, 32'h1F);
		wait_pk; chk("peak", 32'(pk), 32'h1);
		chk("duty", 32'({pwm.level[2], pwm.level[0]}), 32'h1);
		chk("oe", 32'(pwm.oe), 32'h3F);
		bus(1, `TPO_OFS_STAT, 0); chk("noarm", 32'(pk), 32'h1);
		bus(0, `TPO_OFS_STAT, 0); chk("flag", 32'(q[0]), 32'h1);
		bus(1, `TPO_OFS_STAT, 2);
		repeat (2) @(posedge clk);
		chk("clear", 32'(pk), 32'h0);
		{adc_n, up_n, dn_n} = '0;
		for (i = 0; i < 8; i++) begin
			repeat ($urandom % 9) @(posedge clk);
			bus(0, `TPO_OFS_CNT, 0); chk("cnt", 32'(q >= 4 && q <= 24), 32'h1);
		end
		// Two full carrier periods so the pulse count does not hinge on the random gaps
		repeat (80) @(posedge clk);
		chk("adc", 32'(adc_n > 2), 32'h1);
		chk("sync", 32'(up_n > 20 && dn_n > 20), 32'h1);
		bus(1, `TPO_OFS_CTRL, 32'h66);
		{adc_n, xf_n} = '0;
		repeat (100) @(posedge clk);
		chk("adc_off", adc_n, 0);
		chk("xfer", 32'(xf_n > 2), 32'h1);
		// Falling edge on the sync input restarts the carrier
		bus(1, `TPO_OFS_MODE, 32'h17);
		sdrv_en <= 1'b1; sdrv <= 1'b1;
		repeat (2 + $urandom % 30) @(posedge clk);
		sdrv <= 1'b0;
		repeat (3) @(posedge clk);
		bus(0, `TPO_OFS_CNT, 0); chk("reload", 32'(q >= 4 && q <= 10), 32'h1);
		sdrv_en <= 1'b0;
		bus(1, `TPO_OFS_SDCS, 32'h100);
		fault <= 3'h1;
		repeat (8) @(posedge clk);
		chk("sd_edge", 32'({sdi, pwm.oe}), 32'h40);
		fault <= 3'h0;
		bus(0, `TPO_OFS_SDCS, 0);
		bus(1, `TPO_OFS_SDCS, 32'h100);
		repeat (3) @(posedge clk);
		chk("sd_clr", 32'({sdi, pwm.oe}), 32'h3F);
		for (m = 1; m < 4; m++) begin
			dv = (m == 1) ? 8 : (m == 2) ? 16 : 128;
			bus(1, `TPO_OFS_SDCS, 32'h100 | (m << 2));
			fault <= 3'h2;
			repeat (14 * dv) @(posedge clk);
			fault <= 3'h0;
			// Let one sampling tick see the high level so the low run restarts
			repeat (dv + 4) @(posedge clk);
			chk("sd_short", 32'(sdi), 32'h0);
			fault <= 3'h2;
			repeat (18 * dv + 8) @(posedge clk);
			chk("sd_long", 32'(sdi), 32'h1);
			fault <= 3'h0;
			bus(0, `TPO_OFS_SDCS, 0);
			bus(1, `TPO_OFS_SDCS, 32'h100);
		end
		stby <= 1'b1;
		repeat (2) @(posedge clk);
		chk("stby_hiz", 32'(pwm.oe), 32'h0);
		stby <= 1'b0; cstop <= 1'b1;
		repeat (2) @(posedge clk);
		chk("halt_hiz", 32'(pwm.oe), 32'h0);
		cstop <= 1'b0;
		// Stop, flip the positive level, then run again
		bus(1, `TPO_OFS_MODE, 32'h1A);
		bus(1, `TPO_OFS_MODE, 32'h1E);
		repeat (60) @(posedge clk);
		chk("level", 32'({pwm.level[2], pwm.level[0]}), 32'h2);
		report_and_stop;
	end
endmodule // three_phase_pwm_output_stage_test
